// file: rtl/adcc_core.v
// Function
// [R1] Interrupt enable clear: done flag sets at conversion end, holds until result read.
// [R2] Interrupt enable set: done flag never sets and reads zero.
// [R3] Reset clears the done flag.
// [R4] Software writes zero into the done flag position.
// [R5] Interrupt enable set: request at conversion end, dropped on result read or control write.
// [R6] Reset clears the interrupt enable.
// [R7] Continuous bit repeats conversions, else one; reset clears it.
// [R8] Channel codes 0..3 select pins 0, 1, 4 and 5.
// [R9] Codes 1d, 1e select high and low references; others give unknown. The code returns zero for them instead (R18).
// [R10] All-ones channel code powers off; reset loads all ones.
// [R11] Software waits one conversion after leaving power-off before using results.
// [R12] One 8-bit read-only result register updated on each conversion.
// [R13] Three-bit prescaler divides bus clock by 1, 2, 4, 8 or 16.
// [R14] Software discards data of a conversion interrupted by a control write.
// [R15] Conversion starts at first converter clock edge after a control write.
// [R16] A conversion lasts sixteen converter clock cycles.
// [R17] Continuous mode overwrites the result whether read or not.
// [R18] Unused channel codes return zero with normal conversion timing.
`timescale 1ns/1ps
`include "adcc_defs.vh"

module adcc_core (
    // Clock and reset
    input wire ref_clk_i,
    input wire rst_n_i,
    // Register port
    input wire [2:0] reg_addr_i,
    input wire [7:0] reg_wdata_i,
    input wire reg_wr_i,
    input wire reg_rd_i,
    output reg [7:0] reg_rdata_o,
    // Digitised samples of the analog sources
    input wire [7:0] port_a_pin0_i,
    input wire [7:0] port_a_pin1_i,
    input wire [7:0] port_a_pin4_i,
    input wire [7:0] port_a_pin5_i,
    input wire [7:0] analog_high_ref_i,
    input wire [7:0] analog_low_ref_i,
    // Converter status
    output reg [4:0] selected_analog_input_o,
    output reg powered_on_o,
    output reg busy_o,
    // Interrupts
    output reg conv_irq_o,
    output reg irq_o
);

// ==========================================
// State encoding, one-hot
localparam ST_IDLE = 3'b001;
localparam ST_WAIT = 3'b010;
localparam ST_CONV = 3'b100;

reg [2:0] state;
reg [2:0] next_state;
reg irq_enable;
reg continuous_convert;
reg [4:0] channel_select;
reg done_flag;
reg [7:0] conv_result;
reg [2:0] clock_prescale;
reg [4:0] tick_cnt;
reg conv_req;
reg [1:0] irq_stat;
reg [1:0] irq_mask;
reg [7:0] sync1_p0, sync1_p1, sync1_p4, sync1_p5, sync1_hi, sync1_lo;
reg [7:0] sync2_p0, sync2_p1, sync2_p4, sync2_p5, sync2_hi, sync2_lo;
reg [7:0] sample;
reg sample_known;
reg [7:0] next_rdata;
wire tick;
wire scr_wr;
wire res_rd;
wire conv_end;
wire [7:0] scr_view;

assign scr_wr = reg_wr_i && (reg_addr_i == `ADCC_ADDR_SCR);
assign res_rd = reg_rd_i && (reg_addr_i == `ADCC_ADDR_RESULT);
assign conv_end = (state == ST_CONV) && tick && (tick_cnt == `ADCC_CONV_LAST);

// ==========================================
// Converter clock source
adcc_prescaler i_adcc_prescaler (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .clock_prescale_i(clock_prescale),
    .restart_i(scr_wr),
    .tick_o(tick)
);

// ==========================================
// Two-stage synchronisers for pin-side samples
always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
        sync1_p0 <= 8'h00;
        sync1_p1 <= 8'h00;
        sync1_p4 <= 8'h00;
        sync1_p5 <= 8'h00;
        sync1_hi <= 8'h00;
        sync1_lo <= 8'h00;
        sync2_p0 <= 8'h00;
        sync2_p1 <= 8'h00;
        sync2_p4 <= 8'h00;
        sync2_p5 <= 8'h00;
        sync2_hi <= 8'h00;
        sync2_lo <= 8'h00;
    end else begin
        sync1_p0 <= port_a_pin0_i;
        sync1_p1 <= port_a_pin1_i;
        sync1_p4 <= port_a_pin4_i;
        sync1_p5 <= port_a_pin5_i;
        sync1_hi <= analog_high_ref_i;
        sync1_lo <= analog_low_ref_i;
        sync2_p0 <= sync1_p0;
        sync2_p1 <= sync1_p1;
        sync2_p4 <= sync1_p4;
        sync2_p5 <= sync1_p5;
        sync2_hi <= sync1_hi;
        sync2_lo <= sync1_lo;
    end
end

// ==========================================
// Input multiplexer
always @* begin
    sample_known = 1'b1;
    case (channel_select)
        `ADCC_CH_PIN0: sample = sync2_p0; // R8
        `ADCC_CH_PIN1: sample = sync2_p1; // R8
        `ADCC_CH_PIN4: sample = sync2_p4; // R8
        `ADCC_CH_PIN5: sample = sync2_p5; // R8
        `ADCC_CH_HIGH_REF: sample = sync2_hi; // R9
        `ADCC_CH_LOW_REF: sample = sync2_lo; // R9
        default: begin
            // Unknown in silicon; fixed zero keeps simulation clean
            sample = `ADCC_UNUSED_RESULT; // R18
            sample_known = 1'b0;
        end
    endcase
end

// ==========================================
// Control register and pending start request
always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
        irq_enable <= 1'b0; // R6
        continuous_convert <= 1'b0; // R7
        channel_select <= `ADCC_CH_RESET; // R10
        clock_prescale <= `ADCC_DIV_RESET;
        conv_req <= 1'b0;
    end else begin
        if (scr_wr) begin
            // Done flag position is ignored on write, software keeps it zero
            irq_enable <= reg_wdata_i[`ADCC_SCR_IRQEN]; // R4
            continuous_convert <= reg_wdata_i[`ADCC_SCR_CONT];
            channel_select <= reg_wdata_i[`ADCC_SCR_CH_HI:`ADCC_SCR_CH_LO];
            conv_req <= (reg_wdata_i[`ADCC_SCR_CH_HI:`ADCC_SCR_CH_LO] != `ADCC_CH_OFF);
        end else if (tick) begin
            conv_req <= 1'b0;
        end
        if (reg_wr_i && (reg_addr_i == `ADCC_ADDR_CLKDIV)) begin
            clock_prescale <= reg_wdata_i[`ADCC_DIV_HI:`ADCC_DIV_LO];
        end
    end
end

// ==========================================
// Conversion sequencer
always @* begin
    next_state = state;
    case (state)
        ST_IDLE: begin
            if (conv_req) begin
                next_state = ST_WAIT;
            end
        end
        ST_WAIT: begin
            if (tick) begin
                next_state = ST_CONV; // R15
            end
        end
        ST_CONV: begin
            if (conv_end) begin
                // Continuous mode rolls straight into the next sample
                next_state = continuous_convert ? ST_CONV : ST_IDLE; // R7
            end
        end
        default: next_state = ST_IDLE;
    endcase
    // A control write aborts and restarts; power-off sends the sequencer back to idle
    if (scr_wr) begin
        next_state = (reg_wdata_i[`ADCC_SCR_CH_HI:`ADCC_SCR_CH_LO] == `ADCC_CH_OFF) ?
            ST_IDLE : ST_WAIT; // R10
    end
end

always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
        state <= ST_IDLE;
        tick_cnt <= 5'h00;
    end else begin
        state <= next_state;
        if (scr_wr || (state != ST_CONV)) begin
            tick_cnt <= 5'h00;
        end else if (tick) begin
            // Sixteen converter edges per conversion
            tick_cnt <= (tick_cnt == `ADCC_CONV_LAST) ? 5'h00 : tick_cnt + 5'h01; // R16
        end
    end
end

// ==========================================
// Result, done flag and conversion interrupt
always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
        conv_result <= 8'h00;
        done_flag <= 1'b0; // R3
        conv_irq_o <= 1'b0;
    end else begin
        if (conv_end) begin
            conv_result <= sample; // R12 R17
        end
        // Set wins over a same-cycle clearing read
        if (conv_end && !irq_enable) begin
            done_flag <= 1'b1; // R1
        end else if (res_rd || irq_enable) begin
            done_flag <= 1'b0; // R2
        end
        if (conv_end && irq_enable) begin
            conv_irq_o <= 1'b1; // R5
        end else if (res_rd || scr_wr) begin
            conv_irq_o <= 1'b0; // R5
        end
    end
end

// ==========================================
// Sticky event status, write one to clear; set wins
always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
        irq_stat <= 2'h0;
        irq_mask <= 2'h0;
        irq_o <= 1'b0;
    end else begin
        if (reg_wr_i && (reg_addr_i == `ADCC_ADDR_IRQ_MASK)) begin
            irq_mask <= reg_wdata_i[1:0];
        end
        irq_stat[`ADCC_EV_DONE] <= conv_end | (irq_stat[`ADCC_EV_DONE] &
            ~(reg_wr_i && (reg_addr_i == `ADCC_ADDR_IRQ_STAT) && reg_wdata_i[`ADCC_EV_DONE]));
        irq_stat[`ADCC_EV_ERR] <= (conv_end & ~sample_known) | (irq_stat[`ADCC_EV_ERR] &
            ~(reg_wr_i && (reg_addr_i == `ADCC_ADDR_IRQ_STAT) && reg_wdata_i[`ADCC_EV_ERR]));
        irq_o <= |(irq_stat & irq_mask);
    end
end

// ==========================================
// Read data, one cycle after the strobe
assign scr_view = {done_flag & ~irq_enable, irq_enable, continuous_convert, channel_select};

always @* begin
    next_rdata = 8'h00;
    if (reg_addr_i == `ADCC_ADDR_SCR) begin
        next_rdata = scr_view; // R2
    end else if (reg_addr_i == `ADCC_ADDR_RESULT) begin
        next_rdata = conv_result;
    end else if (reg_addr_i == `ADCC_ADDR_CLKDIV) begin
        next_rdata = {clock_prescale, 5'h00};
    end else if (reg_addr_i == `ADCC_ADDR_IRQ_STAT) begin
        next_rdata = {6'h00, irq_stat};
    end else if (reg_addr_i == `ADCC_ADDR_IRQ_MASK) begin
        next_rdata = {6'h00, irq_mask};
    end
end

always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
        reg_rdata_o <= 8'h00;
    end else begin
        // Zero outside read cycles keeps the bus quiet
        reg_rdata_o <= reg_rd_i ? next_rdata : 8'h00;
    end
end

// ==========================================
// Status outputs
always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
        selected_analog_input_o <= `ADCC_CH_RESET;
        powered_on_o <= 1'b0;
        busy_o <= 1'b0;
    end else begin
        selected_analog_input_o <= channel_select;
        powered_on_o <= (channel_select != `ADCC_CH_OFF); // R10
        busy_o <= (next_state != ST_IDLE);
    end
end

endmodule // adcc_core

// file: rtl/adcc_defs.vh
`ifndef ADCC_DEFS_VH
`define ADCC_DEFS_VH

// ==========================================
// Register addresses on the local port
`define ADCC_ADDR_W 3
`define ADCC_ADDR_SCR 3'h0
`define ADCC_ADDR_RESULT 3'h1
`define ADCC_ADDR_CLKDIV 3'h2
`define ADCC_ADDR_IRQ_STAT 3'h3
`define ADCC_ADDR_IRQ_MASK 3'h4

// ==========================================
// Status and control field positions
`define ADCC_SCR_DONE 7
`define ADCC_SCR_IRQEN 6
`define ADCC_SCR_CONT 5
`define ADCC_SCR_CH_HI 4
`define ADCC_SCR_CH_LO 0

// Clock divider field (bits 7:5)
`define ADCC_DIV_HI 7
`define ADCC_DIV_LO 5

// ==========================================
// Reset values
`define ADCC_CH_RESET 5'h1f
`define ADCC_DIV_RESET 3'h0

// ==========================================
// Channel codes
`define ADCC_CH_PIN0 5'h00
`define ADCC_CH_PIN1 5'h01
`define ADCC_CH_PIN4 5'h02
`define ADCC_CH_PIN5 5'h03
`define ADCC_CH_HIGH_REF 5'h1d
`define ADCC_CH_LOW_REF 5'h1e
`define ADCC_CH_OFF 5'h1f
`define ADCC_UNUSED_RESULT 8'h00

// ==========================================
// Conversion timing
`define ADCC_CONV_TICKS 5'h10
`define ADCC_CONV_LAST 5'h0f

// Event status bits
`define ADCC_EV_DONE 0
`define ADCC_EV_ERR 1

`endif

// file: rtl/adcc_prescaler.v
`timescale 1ns/1ps
`include "adcc_defs.vh"

// Converter clock tick generator: one-cycle pulse every 1,2,4,8 or 16 bus clocks
module adcc_prescaler (
    // Clock and reset
    input wire ref_clk_i,
    input wire rst_n_i,
    // Control
    input wire [2:0] clock_prescale_i,
    input wire restart_i,
    // Tick
    output reg tick_o
);

reg [3:0] div_cnt;
reg [3:0] div_max;

// ==========================================
// Divide ratio decode
always @* begin
    case (clock_prescale_i) // R13
        3'h0: div_max = 4'h0;
        3'h1: div_max = 4'h1;
        3'h2: div_max = 4'h3;
        3'h3: div_max = 4'h7;
        default: div_max = 4'hf; // Top bit set is /16
    endcase
end

// ==========================================
// Counter; restart realigns so a start lands on the next converter edge
always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
        div_cnt <= 4'h0;
        tick_o <= 1'b0;
    end else if (restart_i) begin
        div_cnt <= 4'h0;
        tick_o <= 1'b0;
    end else if (div_cnt >= div_max) begin
        div_cnt <= 4'h0;
        tick_o <= 1'b1;
    end else begin
        div_cnt <= div_cnt + 4'h1;
        tick_o <= 1'b0;
    end
end

endmodule // adcc_prescaler

// file: test/adcc_core_properties.sv
`timescale 1ns/1ps
// ======================================
// Port checker for the converter control block
module adcc_core_properties (
    // Clock and reset
    input wire ref_clk_i,
    input wire rst_n_i,
    // Register port
    input wire [2:0] reg_addr_i,
    input wire [7:0] reg_wdata_i,
    input wire reg_wr_i,
    input wire reg_rd_i,
    input wire [7:0] reg_rdata_o,
    // Status
    input wire [4:0] selected_analog_input_o,
    input wire powered_on_o,
    input wire busy_o,
    input wire conv_irq_o
);
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);

    // Bus answers stand only after a mapped read
    chk_rdata_idle: assert property (reg_rdata_o != 8'h00 |->
        $past(reg_rd_i) && $past(reg_addr_i) < 3'h5) else $error("stray read data");
    chk_done_masked: assert property ($past(reg_rd_i && reg_addr_i == 3'h0)
        && reg_rdata_o[6] |-> !reg_rdata_o[7]) else $error("done flag with irq enable");
    // Request falls only for its two causes
    chk_irq_cause: assert property ($fell(conv_irq_o) |->
        $past(reg_wr_i && reg_addr_i == 3'h0 || reg_rd_i && reg_addr_i == 3'h1))
        else $error("request dropped without cause");
    chk_irq_clear: assert property (reg_wr_i && reg_addr_i == 3'h0
        || reg_rd_i && reg_addr_i == 3'h1 |=> !conv_irq_o || $rose(conv_irq_o))
        else $error("request not dropped");
    chk_irq_end: assert property ($rose(conv_irq_o) |-> $past(busy_o))
        else $error("request without conversion");
    // Channel copy follows the control write
    chk_sel_write: assert property (reg_wr_i && reg_addr_i == 3'h0 |-> ##2
        selected_analog_input_o == $past(reg_wdata_i[4:0], 2)) else $error("channel copy");
    chk_power_flag: assert property (powered_on_o ==
        (selected_analog_input_o != 5'h1f)) else $error("power flag mismatch");
    // Busy leads the channel copy by one cycle after a start write
    chk_off_idle: assert property (selected_analog_input_o == 5'h1f
        && !$past(reg_wr_i && reg_addr_i == 3'h0)
        |-> !busy_o) else $error("busy while powered off");
    chk_start_busy: assert property (reg_wr_i && reg_addr_i == 3'h0
        && reg_wdata_i[4:0] != 5'h1f |-> ##[1:2] busy_o) else $error("no start");
endmodule // adcc_core_properties

bind adcc_core adcc_core_properties i_adcc_core_properties (.ref_clk_i, .rst_n_i, .reg_addr_i,
    .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .selected_analog_input_o, .powered_on_o,
    .busy_o, .conv_irq_o);

// file: test/adcc_core_bench.sv
`timescale 1ns/1ps
// ======================================
// Self-checking bench for the converter control block
module adcc_core_bench;
    reg ref_clk_i = 1'b0;
    reg rst_n_i = 1'b0;
    reg [2:0] reg_addr_i = 3'h0;
    reg [7:0] reg_wdata_i = 8'h00;
    reg reg_wr_i = 1'b0;
    reg reg_rd_i = 1'b0;
    reg [7:0] pin [0:5]; // Pins 0,1,4,5, high and low reference
    reg [39:0] codes = {5'h1b, 5'h04, 5'h1e, 5'h1d, 5'h03, 5'h02, 5'h01, 5'h00};
    reg [63:0] exps = {8'h00, 8'h00, 8'h01, 8'hee, 8'h55, 8'h44, 8'h22, 8'h11};
    wire [7:0] rdata;
    wire [4:0] sel;
    wire pwr, busy, cirq, irq;
    integer error_cnt = 0;
    integer total_checks = 0;
    integer cyc = 0;
    integer n, i, nd;

    adcc_core i_adcc_core (.ref_clk_i, .rst_n_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
        .reg_rd_i, .reg_rdata_o(rdata), .port_a_pin0_i(pin[0]), .port_a_pin1_i(pin[1]),
        .port_a_pin4_i(pin[2]), .port_a_pin5_i(pin[3]), .analog_high_ref_i(pin[4]),
        .analog_low_ref_i(pin[5]), .selected_analog_input_o(sel), .powered_on_o(pwr),
        .busy_o(busy), .conv_irq_o(cirq), .irq_o(irq));

    // 100 MHz bus clock
    initial forever #5 ref_clk_i = ~ref_clk_i;

    // Hang guard, well above the few thousand cycles needed
    always @(posedge ref_clk_i) begin
        cyc = cyc + 1;
        if (cyc == 20000) begin
            error_cnt = error_cnt + 1;
            results;
        end
    end

    // ======================================
    // Shared tasks
    task check(input [7:0] got, input [7:0] exp);
        begin
            total_checks = total_checks + 1;
            if (got !== exp) begin
                error_cnt = error_cnt + 1;
                $display("BAD %0t got %h expected %h", $time, got, exp);
            end
        end
    endtask
    task wr(input [2:0] a, input [7:0] v);
        begin
            @(posedge ref_clk_i);
            reg_wr_i <= 1'b1;
            reg_addr_i <= a;
            reg_wdata_i <= v;
            @(posedge ref_clk_i);
            reg_wr_i <= 1'b0;
        end
    endtask
    // Read data stand only in the cycle after the strobe
    task rdc(input [2:0] a, input [7:0] exp);
        begin
            @(posedge ref_clk_i);
            reg_rd_i <= 1'b1;
            reg_addr_i <= a;
            @(posedge ref_clk_i);
            reg_rd_i <= 1'b0;
            #1;
            check(rdata, exp);
        end
    endtask
    // Bounded wait for the end of a conversion, cycles waited in n
    task wait_idle;
        begin
            n = 0;
            @(posedge ref_clk_i);
            #1;
            while (busy !== 1'b0 && n < 400) begin
                @(posedge ref_clk_i);
                #1;
                n = n + 1;
            end
        end
    endtask
    task results;
        begin
            $display("checks %0d errors %0d", total_checks, error_cnt);
            if (error_cnt == 0 && total_checks > 0)
                $display("Finished cleanly");
            else
                $display("Finished with errors");
            $finish;
        end
    endtask

    // ======================================
    // Scenarios
    task t_reset;
        begin
            rdc(3'h0, 8'h1f);
            for (i = 2; i < 6; i = i + 1)
                rdc(i[2:0], 8'h00);
            check({7'h0, pwr}, 8'h00);
        end
    endtask
    // Eight channel codes, two of them unused, single conversions with the flag
    task t_chan;
        begin
            // Throwaway conversion after leaving power-off
            wr(3'h0, 8'h00);
            wait_idle;
            for (i = 0; i < 8; i = i + 1) begin
                wr(3'h0, {3'h0, codes[i*5 +: 5]});
                wait_idle;
                check({3'h0, sel}, {3'h0, codes[i*5 +: 5]});
                check({7'h0, pwr}, 8'h01);
                rdc(3'h0, {3'h4, codes[i*5 +: 5]});
                rdc(3'h1, exps[i*8 +: 8]);
                rdc(3'h0, {3'h0, codes[i*5 +: 5]});
            end
            repeat (40) @(posedge ref_clk_i);
            #1;
            check({7'h0, busy}, 8'h00);
            rdc(3'h3, 8'h03);
            wr(3'h3, 8'h03);
        end
    endtask
    // Every prescale code: write to idle spans 17 converter ticks
    task t_div;
        begin
            for (i = 0; i < 8; i = i + 1) begin
                nd = (i > 3) ? 16 : (1 << i);
                wr(3'h2, {i[2:0], 5'h00});
                rdc(3'h2, {i[2:0], 5'h00});
                wr(3'h0, 8'h00);
                wait_idle;
                check({7'h0, n + 3 >= 17 * nd && n <= 17 * nd + 2}, 8'h01);
                rdc(3'h1, 8'h11);
            end
            wr(3'h2, 8'h00);
            wr(3'h3, 8'h01);
        end
    endtask
    task t_irq;
        begin
            wr(3'h4, 8'h01);
            wr(3'h0, 8'h40);
            wait_idle;
            check({7'h0, cirq}, 8'h01);
            @(posedge ref_clk_i);
            #1;
            check({7'h0, irq}, 8'h01);
            rdc(3'h0, 8'h40);
            rdc(3'h1, 8'h11);
            check({7'h0, cirq}, 8'h00);
            wr(3'h3, 8'h01);
            @(posedge ref_clk_i);
            #1;
            check({7'h0, irq}, 8'h00);
            // Masked event: status only, then a control write drops the request
            wr(3'h4, 8'h00);
            wr(3'h0, 8'h41);
            wait_idle;
            check({6'h0, cirq, irq}, 8'h02);
            wr(3'h0, 8'h5f);
            #1;
            check({7'h0, cirq}, 8'h00);
            rdc(3'h3, 8'h01);
            wr(3'h3, 8'h01);
        end
    endtask
    // Reset in mid-run, with the flag set and a conversion running
    task t_rst2;
        begin
            wr(3'h0, 8'h20);
            repeat (40) @(posedge ref_clk_i);
            rdc(3'h0, 8'ha0);
            @(posedge ref_clk_i);
            rst_n_i <= 1'b0;
            repeat (2) @(posedge ref_clk_i);
            rst_n_i <= 1'b1;
            #1;
            check({6'h0, busy, cirq}, 8'h00);
            rdc(3'h0, 8'h1f);
        end
    endtask
    // Continuous mode overwrites the result without reads
    task t_cont;
        begin
            wr(3'h0, 8'h20);
            repeat (40) @(posedge ref_clk_i);
            pin[0] <= 8'h77;
            repeat (60) @(posedge ref_clk_i);
            #1;
            check({7'h0, busy}, 8'h01);
            rdc(3'h1, 8'h77);
            // Aborted conversion is never read back
            wr(3'h0, 8'h1f);
            repeat (3) @(posedge ref_clk_i);
            rdc(3'h0, 8'h1f);
            wr(3'h1, 8'haa);
            rdc(3'h1, 8'h77);
            wr(3'h5, 8'hff);
            rdc(3'h5, 8'h00);
        end
    endtask

    // Main sequence
    initial begin
        for (i = 0; i < 6; i = i + 1)
            pin[i] = exps[i*8 +: 8];
        repeat (5) @(posedge ref_clk_i);
        rst_n_i <= 1'b1;
        t_reset;
        t_chan;
        t_div;
        t_irq;
        t_rst2;
        t_cont;
        results;
    end
endmodule // adcc_core_bench
